/* shared/cefr_pkg.sv */
// Constants and types shared by the receive queue controller
package cefr_pkg;
    // ========================================================
    // Sizes
    localparam int ID_W = 29;
    localparam int NUM_FILT = 16;
    localparam int NUM_PROG = 6;
    localparam int NUM_DRX = 2;
    localparam int NUM_DTX = 3;
    localparam int QMAX = NUM_DRX + NUM_PROG;
    localparam int NUM_BUF = QMAX + NUM_DTX;
    localparam int TX_BASE = QMAX;
    localparam int SDF_W = 18;
    localparam int FIFO_DEPTH = 4;
    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BSEL = 8'h04;
    localparam logic [7:0] OFS_SDFL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_MASK0 = 8'h10;
    localparam logic [7:0] OFS_MASK1 = 8'h14;
    localparam logic [7:0] OFS_FILTEN = 8'h18;
    localparam logic [7:0] OFS_FILTSEL = 8'h1c;
    localparam logic [7:0] OFS_RXID = 8'h20;
    localparam logic [7:0] OFS_RXDLC = 8'h24;
    localparam logic [7:0] OFS_RXDLO = 8'h28;
    localparam logic [7:0] OFS_RXDHI = 8'h2c;
    localparam logic [7:0] OFS_TXSEL = 8'h30;
    localparam logic [7:0] OFS_TXID = 8'h34;
    localparam logic [7:0] OFS_TXCTL = 8'h38;
    localparam logic [7:0] OFS_TXDLO = 8'h3c;
    localparam logic [7:0] OFS_TXDHI = 8'h40;
    // ========================================================
    // Field positions
    localparam int CTRL_F15 = 2;
    localparam int CTRL_FP = 8;
    localparam int CTRL_REL = 16;
    localparam int STAT_DEPTH = 8;
    localparam int STAT_OVR = 16;
    localparam int STAT_BUSY = 17;
    localparam int ID_IDE = 29;
    localparam int ID_RTR = 30;
    localparam int TXC_AUTO = 6;
    localparam int TXC_REQ = 7;
    // ========================================================
    // Types and reset values
    typedef enum logic [1:0] {
        MODE_CONFIG, MODE_NORMAL, MODE_LOOP, MODE_LISTEN
    } cefr_mode_e;
    typedef enum logic {TX_IDLE, TX_BUSY} cefr_tx_e;
    typedef struct packed {
        logic [ID_W-1:0] id;
        logic ide;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
    } cefr_msg_s;
    localparam cefr_mode_e MODE_RST = MODE_CONFIG;
    localparam logic [5:0] BSEL_RST = 6'h00;
    localparam logic [4:0] SDFL_RST = 5'h00;
    localparam logic [15:0] FILTEN_RST = 16'h0000;
endpackage : cefr_pkg

/* hdl/cefr_top.sv */
// Receive queue controller with filters, transmit buffers and skid FIFO
// Notes on behaviour
// - Enhanced mode joins two or more receive buffers into one queue.
// - Any enabled filter, except the last one while it acts as a mask, may accept a message into any queue slot.
// - Queue depth is set by firmware between two and eight buffers.
// - Depth ends just below the lowest programmable buffer set to transmit.
// - With no programmable buffer transmitting, depth is eight.
// - Three dedicated transmit buffers work apart from the queue.
// - Two dedicated receive buffers are always the first queue slots.
// - Six buffers each select transmit or receive; receive ones below the lowest transmit one join queue.
// - Remote frames are answered by programmable buffers without firmware.
// - Sixteen acceptance filters qualify incoming identifiers.
// - Two masks, and the last filter may act as a third mask.
// - Standard frames may also be filtered on leading data bits.
// - Transmission only in normal or loopback mode.
// - Transmit request stays set until the message has been sent.
// - After reset every programmable buffer receives until its bit is set.
// - A hidden assembly buffer takes each frame; only accepted ones move. Here a frame is dropped while an accepted one waits for FIFO room.
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

module cefr_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [W-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [W-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } cefr_fifo_s;
    cefr_fifo_s s, n;
    logic push, pop;

    assign inReady = s.cnt != (AW+1)'(DEPTH);
    assign outValid = s.cnt != '0;
    assign outData = s.mem[s.rd];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wr] = inData;
            n.wr = (s.wr == AW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
        end
        if (pop) begin
            n.rd = (s.rd == AW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
        end
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : cefr_fifo

module cefr_top #(
    parameter int FIFO_DEPTH = cefr_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Received frames from the bus
    input wire logic rxValid,
    input wire cefr_pkg::cefr_msg_s rxMsg,
    // Frames to the bus
    output logic txValid,
    output cefr_pkg::cefr_msg_s txMsg,
    input wire logic txDone
);
    localparam int NB = cefr_pkg::NUM_BUF;
    localparam int NF = cefr_pkg::NUM_FILT;
    localparam int IW = cefr_pkg::ID_W;

    typedef struct packed {
        cefr_pkg::cefr_mode_e mode;
        logic f15Mask;
        logic [cefr_pkg::NUM_PROG-1:0] bsel;
        logic [4:0] sdfl;
        logic [IW-1:0] mask0;
        logic [IW-1:0] mask1;
        logic [NF-1:0] filtEn;
        logic [2*NF-1:0] filtSel;
        logic [NF-1:0][IW:0] filt;
        cefr_pkg::cefr_msg_s [NB-1:0] bufs;
        logic [NB-1:0] transmit_request_bit;
        logic [NB-1:0] rtrAuto;
        logic [cefr_pkg::QMAX-1:0] full;
        logic [2:0] wrIdx;
        logic [2:0] fp;
        logic [3:0] txSel;
        logic ovr;
        logic mabValid;
        cefr_pkg::cefr_msg_s message_assembly_buffer;
        cefr_pkg::cefr_tx_e txSt;
        logic [3:0] txIdx;
        logic txValid;
        cefr_pkg::cefr_msg_s txMsg;
        logic waitReq;
        logic [31:0] rdata;
    } cefr_top_s;

    cefr_top_s s, n;
    logic [3:0] depth, pick, tb;
    logic anyPend, modeTx, accept, lbValid, newValid, fill;
    logic fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
    logic [NF-1:0] hit;
    logic [cefr_pkg::NUM_PROG-1:0] rtrHit;
    logic [IW-1:0] key, lenMask;
    logic [31:0] rdMux;
    cefr_pkg::cefr_msg_s fifoData, rb;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    function automatic logic [2:0] qNext(input logic [2:0] i,
                                         input logic [3:0] d);
        qNext = (4'(i) + 4'h1 >= d) ? 3'h0 : i + 3'h1;
    endfunction : qNext

    // Window index: 0..2 dedicated transmit, 3..8 programmable buffers
    function automatic logic [3:0] txMap(input logic [3:0] sel);
        if (sel < 4'(cefr_pkg::NUM_DTX)) begin
            txMap = 4'(cefr_pkg::TX_BASE) + sel;
        end else if (sel <= 4'h8) begin
            txMap = sel - 4'h1;
        end else begin
            txMap = 4'(cefr_pkg::QMAX - 1);
        end
    endfunction : txMap

    // ========================================================
    // Queue geometry
    always_comb begin
        depth = 4'(cefr_pkg::QMAX);
        for (int i = cefr_pkg::NUM_PROG - 1; i >= 0; i--) begin
            if (s.bsel[i]) begin
                depth = 4'(cefr_pkg::NUM_DRX + i);
            end
        end
    end

    a_depth_full: assert property (s.bsel == '0 |-> depth == 4'h8)
        else $error("depth not eight with all buffers receiving");
    a_depth_range: assert property (depth >= 4'h2 && depth <= 4'h8)
        else $error("queue depth out of range");
    a_depth_first: assert property (
        (s.bsel & 6'h03) == 6'h02 |-> depth == 4'h3)
        else $error("depth ignores first transmit buffer");

    // ========================================================
    // Acceptance filtering on the assembly buffer
    always_comb begin
        lenMask = '1;
        key = s.message_assembly_buffer.id;
        if (!s.message_assembly_buffer.ide) begin
            // Leading data bits sit below the standard identifier
            lenMask[cefr_pkg::SDF_W-1:0] =
                ~({cefr_pkg::SDF_W{1'b1}} >> s.sdfl);
            key = {s.message_assembly_buffer.id[10:0], s.message_assembly_buffer.data[63:46]};
        end
    end

    for (genvar g = 0; g < NF; g++) begin : gFilt
        logic [IW-1:0] m;
        always_comb begin
            case (s.filtSel[2*g +: 2])
                2'h0: m = s.mask0;
                2'h1: m = s.mask1;
                2'h2: m = s.f15Mask ? s.filt[NF-1][IW-1:0] : s.mask0;
                2'h3: m = '1;
            endcase
        end
        assign hit[g] = s.filtEn[g]
            && !(g == NF - 1 && s.f15Mask)
            && s.filt[g][IW] == s.message_assembly_buffer.ide
            && ((key ^ s.filt[g][IW-1:0]) & m & lenMask) == '0;
    end

    assign accept = |hit;

    a_filter15: assert property (s.f15Mask |-> !hit[NF-1])
        else $error("last filter matched while used as mask");

    // Remote frames that a transmit-mode buffer answers by itself
    always_comb begin
        for (int j = 0; j < cefr_pkg::NUM_PROG; j++) begin
            rb = s.bufs[cefr_pkg::NUM_DRX + j];
            rtrHit[j] = s.mabValid && s.message_assembly_buffer.rtr && s.bsel[j]
                && s.rtrAuto[cefr_pkg::NUM_DRX + j]
                && rb.id == s.message_assembly_buffer.id && rb.ide == s.message_assembly_buffer.ide;
        end
        rb = s.bufs[s.fp];
    end

    // ========================================================
    // Transmit selection
    assign modeTx = s.mode == cefr_pkg::MODE_NORMAL
        || s.mode == cefr_pkg::MODE_LOOP;
    assign tb = txMap(s.txSel);

    always_comb begin
        anyPend = 1'b0;
        pick = '0;
        // Dedicated buffers outrank the programmable ones
        for (int k = cefr_pkg::QMAX - 1; k >= cefr_pkg::NUM_DRX; k--) begin
            if (s.transmit_request_bit[k] && s.bsel[k - cefr_pkg::NUM_DRX]) begin
                anyPend = 1'b1;
                pick = 4'(k);
            end
        end
        for (int k = NB - 1; k >= cefr_pkg::TX_BASE; k--) begin
            if (s.transmit_request_bit[k]) begin
                anyPend = 1'b1;
                pick = 4'(k);
            end
        end
    end

    // ========================================================
    // Read decode
    always_comb begin
        rdMux = '0;
        case (address)
            cefr_pkg::OFS_CTRL: begin
                rdMux[1:0] = s.mode;
                rdMux[cefr_pkg::CTRL_F15] = s.f15Mask;
                rdMux[cefr_pkg::CTRL_FP +: 3] = s.fp;
            end
            cefr_pkg::OFS_BSEL: rdMux[5:0] = s.bsel;
            cefr_pkg::OFS_SDFL: rdMux[4:0] = s.sdfl;
            cefr_pkg::OFS_STAT: begin
                rdMux[7:0] = s.full;
                rdMux[cefr_pkg::STAT_DEPTH +: 4] = depth;
                rdMux[cefr_pkg::STAT_OVR] = s.ovr;
                rdMux[cefr_pkg::STAT_BUSY] = s.txValid;
            end
            cefr_pkg::OFS_MASK0: rdMux[IW-1:0] = s.mask0;
            cefr_pkg::OFS_MASK1: rdMux[IW-1:0] = s.mask1;
            cefr_pkg::OFS_FILTEN: rdMux[NF-1:0] = s.filtEn;
            cefr_pkg::OFS_FILTSEL: rdMux = s.filtSel;
            cefr_pkg::OFS_RXID: begin
                rdMux[IW-1:0] = rb.id;
                rdMux[cefr_pkg::ID_IDE] = rb.ide;
                rdMux[cefr_pkg::ID_RTR] = rb.rtr;
            end
            cefr_pkg::OFS_RXDLC: rdMux[3:0] = rb.dlc;
            cefr_pkg::OFS_RXDLO: rdMux = rb.data[31:0];
            cefr_pkg::OFS_RXDHI: rdMux = rb.data[63:32];
            cefr_pkg::OFS_TXSEL: rdMux[3:0] = s.txSel;
            cefr_pkg::OFS_TXID: begin
                rdMux[IW-1:0] = s.bufs[tb].id;
                rdMux[cefr_pkg::ID_IDE] = s.bufs[tb].ide;
                rdMux[cefr_pkg::ID_RTR] = s.bufs[tb].rtr;
            end
            cefr_pkg::OFS_TXCTL: begin
                rdMux[3:0] = s.bufs[tb].dlc;
                rdMux[cefr_pkg::TXC_AUTO] = s.rtrAuto[tb];
                rdMux[cefr_pkg::TXC_REQ] = s.transmit_request_bit[tb];
            end
            cefr_pkg::OFS_TXDLO: rdMux = s.bufs[tb].data[31:0];
            cefr_pkg::OFS_TXDHI: rdMux = s.bufs[tb].data[63:32];
            default: begin
                if (address[7:6] == 2'h2) begin
                    rdMux[IW:0] = s.filt[address[5:2]];
                end
            end
        endcase
    end

    // ========================================================
    // Next state
    assign fifoInValid = s.mabValid && accept;
    assign fifoOutReady = !s.full[s.wrIdx] && 4'(s.wrIdx) < depth;
    assign fill = fifoOutValid && fifoOutReady;
    // Loopback frame is ready in the cycle that ends the transmission
    assign lbValid = s.txSt == cefr_pkg::TX_BUSY
        && s.mode == cefr_pkg::MODE_LOOP;
    assign newValid = lbValid || (rxValid
        && (s.mode == cefr_pkg::MODE_NORMAL
        || s.mode == cefr_pkg::MODE_LISTEN));

    always_comb begin
        n = s;
        // Transmit engine
        unique case (s.txSt)
            cefr_pkg::TX_IDLE: begin
                if (modeTx && anyPend) begin
                    n.txSt = cefr_pkg::TX_BUSY;
                    n.txIdx = pick;
                    n.txValid = 1'b1;
                    n.txMsg = s.bufs[pick];
                end
            end
            cefr_pkg::TX_BUSY: begin
                // Loopback completes internally without the bus
                if (txDone || s.mode == cefr_pkg::MODE_LOOP) begin
                    n.transmit_request_bit[s.txIdx] = 1'b0;
                    n.txValid = 1'b0;
                    n.txSt = cefr_pkg::TX_IDLE;
                end
            end
        endcase
        // Bus slave: answer one cycle after the request is seen
        n.waitReq = !((read || write) && s.waitReq);
        if (read && s.waitReq) begin
            n.rdata = rdMux;
        end
        if (write && !s.waitReq) begin
            case (address)
                cefr_pkg::OFS_CTRL: begin
                    n.mode = cefr_pkg::cefr_mode_e'(writedata[1:0]);
                    n.f15Mask = writedata[cefr_pkg::CTRL_F15];
                    if (writedata[cefr_pkg::CTRL_REL]) begin
                        n.full[s.fp] = 1'b0;
                        n.fp = qNext(s.fp, depth);
                    end
                end
                cefr_pkg::OFS_BSEL: n.bsel = writedata[5:0];
                cefr_pkg::OFS_SDFL: n.sdfl = writedata[4:0];
                cefr_pkg::OFS_STAT: begin
                    if (writedata[cefr_pkg::STAT_OVR]) begin
                        n.ovr = 1'b0;
                    end
                end
                cefr_pkg::OFS_MASK0: n.mask0 = writedata[IW-1:0];
                cefr_pkg::OFS_MASK1: n.mask1 = writedata[IW-1:0];
                cefr_pkg::OFS_FILTEN: n.filtEn = writedata[NF-1:0];
                cefr_pkg::OFS_FILTSEL: n.filtSel = writedata;
                cefr_pkg::OFS_TXSEL: n.txSel = writedata[3:0];
                cefr_pkg::OFS_TXID: begin
                    n.bufs[tb].id = writedata[IW-1:0];
                    n.bufs[tb].ide = writedata[cefr_pkg::ID_IDE];
                    n.bufs[tb].rtr = writedata[cefr_pkg::ID_RTR];
                end
                cefr_pkg::OFS_TXCTL: begin
                    n.bufs[tb].dlc = writedata[3:0];
                    n.rtrAuto[tb] = writedata[cefr_pkg::TXC_AUTO];
                    // A clear cannot withdraw a frame on the wire
                    if (writedata[cefr_pkg::TXC_REQ]
                        || !(s.txValid && s.txIdx == tb)) begin
                        n.transmit_request_bit[tb] = writedata[cefr_pkg::TXC_REQ];
                    end
                end
                cefr_pkg::OFS_TXDLO: n.bufs[tb].data[31:0] = writedata;
                cefr_pkg::OFS_TXDHI: n.bufs[tb].data[63:32] = writedata;
                default: begin
                    if (address[7:6] == 2'h2) begin
                        n.filt[address[5:2]] = writedata[IW:0];
                    end
                end
            endcase
        end
        // Assembly buffer: rejected frames are dropped, accepted wait
        if (s.mabValid && (!accept || fifoInReady)) begin
            n.mabValid = 1'b0;
            for (int j = 0; j < cefr_pkg::NUM_PROG; j++) begin
                if (rtrHit[j]) begin
                    n.transmit_request_bit[cefr_pkg::NUM_DRX + j] = 1'b1;
                end
            end
        end
        if (newValid) begin
            if (n.mabValid) begin
                n.ovr = 1'b1;
            end else begin
                n.message_assembly_buffer = lbValid ? s.txMsg : rxMsg;
                n.mabValid = 1'b1;
            end
        end
        // Queue fill in ascending order with wrap to slot zero
        if (4'(s.wrIdx) >= depth) begin
            n.wrIdx = 3'h0;
        end
        if (fill) begin
            n.bufs[s.wrIdx] = fifoData;
            n.full[s.wrIdx] = 1'b1;
            n.wrIdx = qNext(s.wrIdx, depth);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.mode <= cefr_pkg::MODE_RST;
            s.bsel <= cefr_pkg::BSEL_RST;
            s.sdfl <= cefr_pkg::SDFL_RST;
            s.filtEn <= cefr_pkg::FILTEN_RST;
            s.waitReq <= 1'b1;
        end else begin
            s <= n;
        end
    end

    cefr_fifo #(
        .W($bits(cefr_pkg::cefr_msg_s)),
        .DEPTH(FIFO_DEPTH)
    ) uFifo (
        .clk(clk),
        .nrst(nrst),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(s.message_assembly_buffer),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoData)
    );

    assign readdata = s.rdata;
    assign waitrequest = s.waitReq;
    assign txValid = s.txValid;
    assign txMsg = s.txMsg;

    // ========================================================
    // Checks
    a_wait_answer: assert property (
        (read || write) && s.waitReq |=> !s.waitReq)
        else $error("bus request not answered in one cycle");
    a_tx_mode_gate: assert property ($rose(s.txValid) |-> $past(modeTx))
        else $error("transmit started outside normal or loopback");
    a_transmit_request_bit_held: assert property (
        s.txValid && !txDone && s.mode != cefr_pkg::MODE_LOOP
        |=> s.txValid && s.transmit_request_bit[s.txIdx])
        else $error("transmit request dropped before completion");
    a_transmit_request_bit_clear: assert property (
        s.txValid && txDone && s.mode != cefr_pkg::MODE_LOOP
        && !write && !(|rtrHit)
        |=> !s.transmit_request_bit[$past(s.txIdx)] && !s.txValid)
        else $error("transmit request not cleared on completion");
    a_fill_wrap: assert property (
        fill && 4'(s.wrIdx) + 4'h1 >= depth |=> s.wrIdx == 3'h0)
        else $error("queue write index did not wrap");
    a_mab_drop: assert property (
        s.mabValid && !accept |=> !s.mabValid || $past(newValid))
        else $error("rejected frame kept in assembly buffer");
    a_rtr_auto: assert property (
        s.mabValid && (|rtrHit) && (!accept || fifoInReady)
        |=> |(s.transmit_request_bit[cefr_pkg::QMAX-1:cefr_pkg::NUM_DRX]
        & $past(rtrHit)))
        else $error("remote frame not answered automatically");
endmodule : cefr_top

/* bench/cefr_bus_model.sv */
// Behavioural model of the other nodes on the shared bus
`timescale 1ns/1ps
module cefr_bus_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Frames toward the controller
    output logic rxValid,
    output cefr_pkg::cefr_msg_s rxMsg,
    // Frames from the controller
    input wire logic txValid,
    input wire cefr_pkg::cefr_msg_s txMsg,
    output logic txDone,
    // Acknowledge delay in cycles, set by the bench
    input wire logic [7:0] ackDelay
);
    logic [7:0] waitQ;
    cefr_pkg::cefr_msg_s lastTx;
    int txCount;
    initial begin
        rxValid = 1'b0;
        rxMsg = '0;
    end
    // ========================================================
    // Frame delivery
    // Idle bus shows the inverse, so a stale frame is never reused
    task automatic send(input cefr_pkg::cefr_msg_s m);
        @(posedge clk);
        rxValid <= 1'b1;
        rxMsg <= m;
        @(posedge clk);
        rxValid <= 1'b0;
        rxMsg <= ~m;
    endtask : send
    // ========================================================
    // Acknowledge
    // Pulse lasts one cycle; count restarts from zero in the cycle after it
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            txDone <= 1'b0;
            waitQ <= 8'h00;
            txCount <= 0;
            lastTx <= '0;
        end else if (txDone) begin
            txDone <= 1'b0;
            waitQ <= 8'h00;
        end else if (txValid) begin
            if (waitQ == ackDelay) begin
                txDone <= 1'b1;
                lastTx <= txMsg;
                txCount <= txCount + 1;
            end else begin
                waitQ <= waitQ + 8'h01;
            end
        end
    end
endmodule : cefr_bus_model

/* bench/cefr_top_tb.sv */
// Self-checking bench for the receive queue controller
`timescale 1ns/1ps
module cefr_top_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] address = 8'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic rxValid;
    logic txValid;
    logic txDone;
    cefr_pkg::cefr_msg_s rxMsg;
    cefr_pkg::cefr_msg_s txMsg;
    logic [7:0] ackDelay = 8'h1e;
    logic [31:0] q;
    cefr_pkg::cefr_msg_s sf;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    cefr_top #(.FIFO_DEPTH(4)) dut (.clk(clk), .nrst(nrst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rxValid(rxValid), .rxMsg(rxMsg),
        .txValid(txValid), .txMsg(txMsg), .txDone(txDone));
    cefr_bus_model bus (.clk(clk), .nrst(nrst), .rxValid(rxValid),
        .rxMsg(rxMsg), .txValid(txValid), .txMsg(txMsg),
        .txDone(txDone), .ackDelay(ackDelay));
    // ========================================================
    // Helpers
    task automatic final_report();
        $display("Mismatches %0d of %0d checks", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        check(q, exp);
    endtask : rd
    function automatic cefr_pkg::cefr_msg_s mk(input logic [28:0] i,
                                               input logic r);
        mk = '0;
        mk.id = i;
        mk.ide = 1'b1;
        mk.rtr = r;
        mk.dlc = 4'h8;
    endfunction : mk
    // ========================================================
    // Timeout
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            final_report();
        end
    end
    // ========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h0000_0800);
        wr(8'h7c, 32'hffff_ffff);
        rd(8'h7c, 32'h0);
        // Depth ends below the lowest transmit buffer
        for (int k = 0; k < 6; k++) begin
            wr(8'h04, 32'h1 << k);
            rd(8'h0c, (k + 2) << 8);
        end
        wr(8'h04, 32'h24);
        rd(8'h0c, 32'h0000_0400);
        // A request made in configuration mode must wait
        wr(8'h30, 32'h0);
        wr(8'h34, 32'h2011_1111);
        wr(8'h38, 32'h88);
        repeat (10) @(posedge clk);
        check(bus.txCount, 0);
        rd(8'h38, 32'h88);
        // Two filters sharing one mask feed the queue
        wr(8'h10, 32'h1fff_ffff);
        wr(8'h8c, 32'h2012_3456);
        wr(8'ha4, 32'h20ab_cdef);
        wr(8'h18, 32'h0208);
        wr(8'h00, 32'h1);
        rd(8'h38, 32'h88);
        bus.send(mk(29'h0123456, 1'b0));
        bus.send(mk(29'h0abcdef, 1'b0));
        bus.send(mk(29'h0555555, 1'b0));
        bus.send(mk(29'h0123456, 1'b0));
        bus.send(mk(29'h0abcdef, 1'b0));
        repeat (40) @(posedge clk);
        rd(8'h38, 32'h08);
        check(bus.txCount, 1);
        check({3'b000, bus.lastTx.id}, 32'h0011_1111);
        rd(8'h0c, 32'h0000_040f);
        rd(8'h20, 32'h2012_3456);
        wr(8'h00, 32'h0001_0001);
        rd(8'h00, 32'h0000_0101);
        rd(8'h20, 32'h20ab_cdef);
        bus.send(mk(29'h0abcdef, 1'b0));
        repeat (10) @(posedge clk);
        rd(8'h0c, 32'h0000_040f);
        // Remote frame answered by a programmable buffer, prompt ack
        ackDelay <= 8'h00;
        wr(8'h30, 32'h5);
        wr(8'h34, 32'h2000_0077);
        wr(8'h38, 32'h40);
        bus.send(mk(29'h0000077, 1'b1));
        repeat (20) @(posedge clk);
        check(bus.txCount, 2);
        check({3'b000, bus.lastTx.id}, 32'h77);
        rd(8'h38, 32'h40);
        // Standard frames also compare their leading data bits
        wr(8'h00, 32'h0001_0001);
        wr(8'h08, 32'h8);
        wr(8'h8c, 32'h048e_9400);
        sf = mk(29'h123, 1'b0);
        sf.ide = 1'b0;
        sf.data[63:56] = 8'h5a;
        bus.send(sf);
        repeat (10) @(posedge clk);
        rd(8'h0c, 32'h0000_040d);
        sf.data[63:56] = 8'ha5;
        bus.send(sf);
        repeat (10) @(posedge clk);
        rd(8'h0c, 32'h0000_040f);
        // Last filter turned into the mask of filter three
        wr(8'h00, 32'h0001_0005);
        wr(8'hbc, 32'h1ffc_0000);
        wr(8'h1c, 32'h80);
        wr(8'h18, 32'h8208);
        rd(8'h00, 32'h0000_0305);
        sf.id = 29'h7ff;
        sf.data[63:56] = 8'h00;
        bus.send(sf);
        repeat (10) @(posedge clk);
        rd(8'h0c, 32'h0000_040b);
        sf.id = 29'h123;
        sf.data[63:56] = 8'h5a;
        bus.send(sf);
        repeat (10) @(posedge clk);
        rd(8'h0c, 32'h0000_040f);
        final_report();
    end
endmodule : cefr_top_tb
